// ==== pkg/plio_pkg.sv ====
// package for the port latch and pin driver block
// assumes one core clock at 10 MHz and active-low asynchronous reset
package plio_pkg;
  localparam int PORT_W = 8;
  localparam logic [7:0] LATCH_RST = 8'hff;
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_PERIOD_NS = 100;
  localparam int STRONG_PULSE_OSC = 2;
  localparam int STRONG_PULSE_NS = STRONG_PULSE_OSC * OSC_PERIOD_NS;
  localparam int STRONG_PULSE_CYC = (STRONG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_BITS = 2;

  // cpu side access strobes for one port
  typedef struct packed {
    logic wr;
    logic rd_latch;
    logic rd_pin;
  } plio_acc_s;

  // drive of one pin
  typedef struct packed {
    logic out;
    logic oe;
  } plio_drv_s;
endpackage : plio_pkg

// ==== design/plio_pullup.sv ====
// active pull-up sequencer for one quasi-bidirectional pin
// assumes pin_sync_i is already synchronised to mclk_i
`timescale 1ns/1ps
module plio_pullup #(
  parameter int PULSE_CYC = plio_pkg::STRONG_PULSE_CYC
) (
  input wire logic mclk_i, // core clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic level_i, // effective output level (latch or pwm)
  input wire logic pin_sync_i, // synchronised pin level
  output logic strong_pullup_o, // strong pull-up on
  output logic weak_keeper_o, // keeper on
  output logic trickle_pullup_o // very weak pull-up on
);
  // the pulse counter is eight bits wide
  if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_bad_pulse
    $error("plio_pullup: PULSE_CYC out of range");
  end

  logic level_q_ff;
  logic [7:0] cnt_ff;
  logic keeper_ff;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) level_q_ff <= 1'b1;
    else level_q_ff <= level_i;
  end

  // strong pulse on each rising edge of the level
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt_ff <= 8'h00;
    else if (level_i && !level_q_ff) cnt_ff <= 8'(PULSE_CYC); // [RULE_14]
    else if (!level_i) cnt_ff <= 8'h00;
    else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
  end

  // keeper holds high after pulse, drops when pin seen low
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) keeper_ff <= 1'b0;
    else if (!level_i) keeper_ff <= 1'b0;
    else if (!pin_sync_i) keeper_ff <= 1'b0; // [RULE_15]
    else if (cnt_ff == 8'h01 || cnt_ff == 8'h00) keeper_ff <= 1'b1; // [RULE_15]
  end

  assign strong_pullup_o = (cnt_ff != 8'h00);
  assign weak_keeper_o = keeper_ff && (cnt_ff == 8'h00);
  assign trickle_pullup_o = level_q_ff;
endmodule : plio_pullup

// ==== design/plio_ports.sv ====
// latch and pin drivers for the open-drain port and the two low quasi pins
// assumes cpu strobes and memory-cycle controls are on mclk_i; pins are async
`timescale 1ns/1ps
// Contract
// [RULE_01] first port: eight open-drain pins from latch
// [RULE_02] memory cycles put address/data on first port
// [RULE_03] latch captures bus on write strobe
// [RULE_04] read latch or read pin onto bus
// [RULE_05] external access sets first-port latch ones
// [RULE_06] external access drives pins push-pull
// [RULE_07] latch one: pin floats as input
// [RULE_08] latch zero: pin driven low
// [RULE_09] second port latch, two low pins
// [RULE_10] low pins pulled high on one, low on zero
// [RULE_11] timer inputs only when latch holds one
// [RULE_12] pulse-width outputs override latch bits
// [RULE_13] bit zero count/pwm a, bit one trigger/pwm b
// [RULE_14] strong pull-up two oscillator periods on rise
// [RULE_15] keeper holds high, drops on external low
// [RULE_16] software avoids gpio use of enabled peripheral pins
// [RULE_17] read-modify-write reads latch not pin
// [RULE_18] reset sets all latch bits to one
module plio_ports #(
  parameter int WIDTH = plio_pkg::PORT_W,
  parameter int PULSE_CYC = plio_pkg::STRONG_PULSE_CYC
) (
  input wire logic mclk_i, // core clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [WIDTH-1:0] bus_wdata_i, // internal bus write data
  input wire plio_pkg::plio_acc_s p0_acc_i, // first port strobes
  input wire plio_pkg::plio_acc_s p1_acc_i, // second port strobes
  input wire logic rmw_i, // read is read-modify-write
  output logic [WIDTH-1:0] bus_rdata_o, // internal bus read data
  input wire logic ext_access_i, // external memory cycle select
  input wire logic [WIDTH-1:0] ext_addr_data_i, // address/data to drive
  output logic [WIDTH-1:0] ext_data_o, // data read back from first port
  input wire logic [WIDTH-1:0] port_zero_pin_i, // first port pin levels
  output logic [WIDTH-1:0] port_zero_out_o, // first port drive value
  output logic [WIDTH-1:0] port_zero_oe_o, // first port output enable
  input wire logic [1:0] pwm_en_i, // pwm routed to low pins
  input wire logic pulse_width_out_a_i, // pwm a waveform
  input wire logic pulse_width_out_b_i, // pwm b waveform
  input wire logic [1:0] port_one_pin_i, // low pin levels
  output logic [1:0] port_one_out_o, // low pin drive low value
  output logic [1:0] port_one_oe_o, // low pin pull-down enable
  output logic [1:0] strong_pullup_o, // strong pull-up per low pin
  output logic [1:0] weak_keeper_o, // keeper per low pin
  output logic [1:0] trickle_pullup_o, // very weak pull-up per low pin
  output logic timer_two_count_input_o, // timer count input
  output logic timer_two_trigger_input_o, // timer trigger input
  output logic [WIDTH-1:0] port_one_latch_o // second port latch for upper pins
);
  // only the byte-wide layout is served: the low-pin split and read mux assume it
  if (WIDTH != 8) begin : g_bad_width
    $error("plio_ports: WIDTH must be 8");
  end
  // the pull-up counter is eight bits wide
  if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_bad_pulse
    $error("plio_ports: PULSE_CYC out of range");
  end
  // two low pins, each with its own pull-up sequencer
  if (plio_pkg::LOW_BITS != 2) begin : g_bad_low
    $error("plio_ports: LOW_BITS must be 2");
  end

  logic [WIDTH-1:0] port_zero_latch_ff;
  logic [WIDTH-1:0] port_one_latch_ff;
  logic [WIDTH-1:0] p0_sync1_ff, p0_sync2_ff;
  logic [1:0] p1_sync1_ff, p1_sync2_ff;
  logic [WIDTH-1:0] nxt_rdata;
  logic [WIDTH-1:0] rdata_ff;
  logic [WIDTH-1:0] p0_out_ff, p0_oe_ff, ext_data_ff;
  logic [1:0] p1_out_ff, p1_oe_ff, sp_ff, wk_ff, tp_ff;
  logic t2_ff, timer_two_trigger_input_ff;
  logic [1:0] level;
  logic [1:0] sp_w, wk_w, tp_w;

  // pin synchronisers: pins are asynchronous, two flops before any logic
  // reset to one so released pins do not look like a falling edge
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p0_sync1_ff <= '1;
      p0_sync2_ff <= '1;
      p1_sync1_ff <= '1;
      p1_sync2_ff <= '1;
    end else begin
      p0_sync1_ff <= port_zero_pin_i;
      p0_sync2_ff <= p0_sync1_ff;
      p1_sync1_ff <= port_one_pin_i;
      p1_sync2_ff <= p1_sync1_ff;
    end
  end

  // first port latch
  // a memory cycle wins over a cpu write landing in the same cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) port_zero_latch_ff <= plio_pkg::LATCH_RST; // [RULE_18]
    else if (ext_access_i) port_zero_latch_ff <= '1; // [RULE_05]
    else if (p0_acc_i.wr) port_zero_latch_ff <= bus_wdata_i; // [RULE_03]
  end

  // second port latch
  // upper six bits only configure pins outside this block
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) port_one_latch_ff <= plio_pkg::LATCH_RST; // [RULE_18] [RULE_09]
    else if (p1_acc_i.wr) port_one_latch_ff <= bus_wdata_i; // [RULE_03]
  end

  // rmw reads take the latch so a loaded pin cannot corrupt the rewrite
  function automatic logic take_latch(input plio_pkg::plio_acc_s acc, input logic rmw);
    take_latch = acc.rd_latch || (acc.rd_pin && rmw); // [RULE_17]
  endfunction : take_latch

  // read mux: rmw and read-latch return latch, read-pin returns pin (second port: low two pins, upper six bits from latch)
  always_comb begin
    nxt_rdata = '0;
    if (take_latch(p0_acc_i, rmw_i)) nxt_rdata = port_zero_latch_ff; // [RULE_04] [RULE_17]
    else if (p0_acc_i.rd_pin) nxt_rdata = p0_sync2_ff; // [RULE_04]
    else if (take_latch(p1_acc_i, rmw_i)) nxt_rdata = port_one_latch_ff; // [RULE_17]
    else if (p1_acc_i.rd_pin) nxt_rdata = {port_one_latch_ff[WIDTH-1:2], p1_sync2_ff}; // [RULE_04]
  end

  // read data stands one cycle, zero when nothing is read
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) rdata_ff <= '0;
    else rdata_ff <= nxt_rdata;
  end

  // first port drivers
  // drivers follow the latch one edge late; memory cycles drive all eight
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p0_out_ff <= '0;
      p0_oe_ff <= '0;
      ext_data_ff <= '0;
    end else begin
      ext_data_ff <= p0_sync2_ff; // [RULE_02]
      if (ext_access_i) begin
        p0_out_ff <= ext_addr_data_i; // [RULE_02] [RULE_06]
        p0_oe_ff <= '1; // [RULE_06]
      end else begin
        p0_out_ff <= '0; // [RULE_01] [RULE_08]
        p0_oe_ff <= ~port_zero_latch_ff; // [RULE_07] [RULE_08]
      end
    end
  end

  // pwm overrides latch on low pins
  assign level[0] = pwm_en_i[0] ? pulse_width_out_a_i : port_one_latch_ff[0]; // [RULE_12] [RULE_13]
  assign level[1] = pwm_en_i[1] ? pulse_width_out_b_i : port_one_latch_ff[1]; // [RULE_12] [RULE_13]

  // one pull-up sequencer per low pin
  genvar gi;
  generate
    for (gi = 0; gi < plio_pkg::LOW_BITS; gi++) begin : g_pu
      plio_pullup #(.PULSE_CYC(PULSE_CYC)) u_pu (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .level_i(level[gi]),
        .pin_sync_i(p1_sync2_ff[gi]),
        .strong_pullup_o(sp_w[gi]),
        .weak_keeper_o(wk_w[gi]),
        .trickle_pullup_o(tp_w[gi])
      );
    end
  endgenerate

  // low pin drivers and timer gating
  // timer inputs see the pin only while the latch holds one, else stuck at zero
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p1_out_ff <= '0;
      p1_oe_ff <= '0;
      sp_ff <= '0;
      wk_ff <= '0;
      tp_ff <= '1;
      t2_ff <= 1'b0;
      timer_two_trigger_input_ff <= 1'b0;
    end else begin
      p1_out_ff <= '0;
      p1_oe_ff <= ~level; // [RULE_10]
      sp_ff <= sp_w; // [RULE_14]
      wk_ff <= wk_w; // [RULE_15]
      tp_ff <= tp_w; // [RULE_10]
      t2_ff <= port_one_latch_ff[0] & p1_sync2_ff[0]; // [RULE_11] [RULE_13]
      timer_two_trigger_input_ff <= port_one_latch_ff[1] & p1_sync2_ff[1]; // [RULE_11] [RULE_13]
    end
  end

  // every output straight from a flop
  assign bus_rdata_o = rdata_ff;
  assign ext_data_o = ext_data_ff;
  assign port_zero_out_o = p0_out_ff;
  assign port_zero_oe_o = p0_oe_ff;
  assign port_one_out_o = p1_out_ff;
  assign port_one_oe_o = p1_oe_ff;
  assign strong_pullup_o = sp_ff;
  assign weak_keeper_o = wk_ff;
  assign trickle_pullup_o = tp_ff;
  assign timer_two_count_input_o = t2_ff;
  assign timer_two_trigger_input_o = timer_two_trigger_input_ff;
  assign port_one_latch_o = port_one_latch_ff;
endmodule : plio_ports

// ==== verification/plio_ports_sva.sv ====
// concurrent checks on the port latch and pin driver block
// assumes one core clock domain; bound onto plio_ports
`timescale 1ns/1ps
module plio_ports_sva #(
  parameter int WIDTH = 8,
  parameter int PULSE_CYC = 2
) (
  input wire logic mclk_i, // core clock
  input wire logic rst_n_i, // async reset, active low
  input wire plio_pkg::plio_acc_s p0_acc_i, // first port strobes
  input wire plio_pkg::plio_acc_s p1_acc_i, // second port strobes
  input wire logic [WIDTH-1:0] bus_rdata_o, // read data
  input wire logic ext_access_i, // memory cycle select
  input wire logic [WIDTH-1:0] port_zero_out_o, // first port drive value
  input wire logic [WIDTH-1:0] port_zero_oe_o, // first port enable
  input wire logic [1:0] pwm_en_i, // pwm routing
  input wire logic [1:0] port_one_pin_i, // low pin levels
  input wire logic [1:0] port_one_out_o, // low pin drive value
  input wire logic [1:0] port_one_oe_o, // low pin pull-down
  input wire logic [1:0] strong_pullup_o, // strong pull-ups
  input wire logic [1:0] weak_keeper_o, // keepers
  input wire logic timer_two_count_input_o, // timer count input
  input wire logic [WIDTH-1:0] port_one_latch_o // second port latch
);
  wire rd_any = p0_acc_i.rd_latch | p0_acc_i.rd_pin | p1_acc_i.rd_latch | p1_acc_i.rd_pin;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_ext_push_pull: assert property (ext_access_i [*2] |-> port_zero_oe_o == 8'hff)
    else $error("first port not driven during memory cycle");
  a_gp_open_drain: assert property (!ext_access_i [*3] |-> (port_zero_out_o & port_zero_oe_o) == 8'h00)
    else $error("first port drives high outside memory cycle");
  a_low_pin_sink: assert property (port_one_out_o == 2'b00)
    else $error("low pin driven high");
  a_low_pin_follow: assert property (!pwm_en_i[0] [*3] |-> port_one_oe_o[0] == !$past(port_one_latch_o[0]))
    else $error("low pin pull-down does not follow latch");
  a_rdata_idle_zero: assert property (!$past(rd_any) |-> bus_rdata_o == 8'h00)
    else $error("read data without read strobe");
  a_pulse_on_rise: assert property ($rose(port_one_latch_o[0]) && !pwm_en_i[0] |-> ##2 strong_pullup_o[0])
    else $error("no strong pull-up after latch rise");
  a_pulse_two_cycles: assert property ($rose(strong_pullup_o[0]) |-> strong_pullup_o[0] [*2] ##1 !strong_pullup_o[0])
    else $error("strong pull-up width wrong");
  a_keeper_drops: assert property (!port_one_pin_i[0] [*5] |-> !weak_keeper_o[0])
    else $error("keeper stays on with pin low");
  a_timer_gated: assert property (timer_two_count_input_o |-> $past(port_one_latch_o[0]))
    else $error("timer input passes with latch zero");
endmodule : plio_ports_sva

bind plio_ports plio_ports_sva #(.WIDTH(WIDTH), .PULSE_CYC(PULSE_CYC)) u_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .p0_acc_i(p0_acc_i), .p1_acc_i(p1_acc_i), .bus_rdata_o(bus_rdata_o), .ext_access_i(ext_access_i),
  .port_zero_out_o(port_zero_out_o), .port_zero_oe_o(port_zero_oe_o), .pwm_en_i(pwm_en_i),
  .port_one_pin_i(port_one_pin_i), .port_one_out_o(port_one_out_o), .port_one_oe_o(port_one_oe_o),
  .strong_pullup_o(strong_pullup_o), .weak_keeper_o(weak_keeper_o),
  .timer_two_count_input_o(timer_two_count_input_o), .port_one_latch_o(port_one_latch_o));

// ==== verification/plio_ext_dev.sv ====
// external devices on the pins: pull-ups and drivers
// assumes released first-port pins follow ext0_i, low pins pulled up
`timescale 1ns/1ps
module plio_ext_dev (
  input wire logic [7:0] out0_i, // first port drive value
  input wire logic [7:0] oe0_i, // first port enable
  input wire logic [7:0] ext0_i, // level of outside world on released pins
  input wire logic [1:0] oe1_i, // low pin pull-down
  input wire logic [1:0] low1_i, // outside device pulls pin low
  output logic [7:0] pin0_o, // first port wire
  output logic [1:0] pin1_o // low pin wire
);
  assign pin0_o = (oe0_i & out0_i) | (~oe0_i & ext0_i);
  assign pin1_o = ~oe1_i & ~low1_i;
endmodule : plio_ext_dev

// ==== verification/plio_ports_tb.sv ====
// self-checking bench for the port latch block
// assumes the external device model and the bound checker
`timescale 1ns/1ps
module plio_ports_tb;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] wdata, ext_ad, ext0, rdata, pin0, out0, oe0, latch1, ed, dv, ext_rd;
  logic [7:0] exp_q[$];
  plio_pkg::plio_acc_s acc0, acc1;
  logic rmw, ext, pwa, pwb, t2c, t2t;
  logic rd_pend = 1'b0;
  logic [1:0] pwm_en, low1, pin1, out1, oe1, keeper, trickle;
  integer seed = 32'hf49f;
  int n_fail = 0;
  int total_checks = 0;
  always #50 mclk_i = ~mclk_i;
  plio_ports dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_wdata_i(wdata), .p0_acc_i(acc0), .p1_acc_i(acc1),
    .rmw_i(rmw), .bus_rdata_o(rdata), .ext_access_i(ext), .ext_addr_data_i(ext_ad), .ext_data_o(ext_rd),
    .port_zero_pin_i(pin0), .port_zero_out_o(out0), .port_zero_oe_o(oe0), .pwm_en_i(pwm_en),
    .pulse_width_out_a_i(pwa), .pulse_width_out_b_i(pwb), .port_one_pin_i(pin1), .port_one_out_o(out1),
    .port_one_oe_o(oe1), .strong_pullup_o(), .weak_keeper_o(keeper), .trickle_pullup_o(trickle),
    .timer_two_count_input_o(t2c), .timer_two_trigger_input_o(t2t), .port_one_latch_o(latch1));
  plio_ext_dev dev_u (.out0_i(out0), .oe0_i(oe0), .ext0_i(ext0), .oe1_i(oe1), .low1_i(low1),
    .pin0_o(pin0), .pin1_o(pin1));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] got);
    total_checks++;
    if (got !== e) begin
      $display("ERROR %s expected %h seen %h", name, e, got);
      n_fail++;
    end
  endtask : chk
  // one strobe cycle; reads note their expected byte
  task automatic acc(input bit port, input logic [2:0] s, input logic [7:0] d, input logic [7:0] e);
    @(posedge mclk_i);
    if (port) acc1 <= s;
    else acc0 <= s;
    wdata <= d;
    if (s[1:0] != 2'b00) exp_q.push_back(e);
    @(posedge mclk_i);
    acc0 <= '0;
    acc1 <= '0;
  endtask : acc
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : cyc
  always @(posedge mclk_i) rd_pend <= acc0.rd_latch | acc0.rd_pin | acc1.rd_latch | acc1.rd_pin;
  always @(negedge mclk_i) begin
    if (rd_pend === 1'b1) chk("bus_rdata_o", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rdata);
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    report_and_stop();
  end
  initial begin
    {wdata, ext_ad, rmw, ext, pwa, pwb, pwm_en, low1} = '0;
    {acc0, acc1} = '0;
    ext0 = 8'hff;
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    acc(0, 3'b010, 8'h00, 8'hff);
    acc(1, 3'b010, 8'h00, 8'hff);
    cyc(1);
    chk("port_zero_oe_o", 8'h00, oe0);
    chk("trickle_pullup_o", 8'h03, {6'h00, trickle});
    $display("test reset done");
    repeat (4) begin
      dv = 8'($random(seed));
      ed = 8'($random(seed));
      @(posedge mclk_i);
      ext0 <= ed;
      acc(0, 3'b100, dv, 8'h00);
      acc(0, 3'b010, 8'h00, dv);
      cyc(3);
      chk("port_zero_oe_o", ~dv, oe0);
      chk("port_zero_out_o", 8'h00, out0);
      acc(0, 3'b001, 8'h00, dv & ed);
      rmw <= 1'b1;
      acc(0, 3'b001, 8'h00, dv);
      rmw <= 1'b0;
    end
    $display("test first port done");
    cyc(1);
    @(posedge mclk_i);
    ext_ad <= 8'($random(seed));
    ext <= 1'b1;
    acc(0, 3'b100, 8'h00, 8'h00);
    cyc(2);
    chk("port_zero_oe_o", 8'hff, oe0);
    chk("port_zero_out_o", ext_ad, out0);
    chk("ext_data_o", ext_ad, ext_rd);
    @(posedge mclk_i);
    ext <= 1'b0;
    acc(0, 3'b010, 8'h00, 8'hff);
    $display("test memory cycle done");
    acc(1, 3'b100, 8'hfc, 8'h00);
    cyc(3);
    chk("port_one_oe_o", 8'h03, {6'h00, oe1});
    chk("timer_inputs", 8'h00, {6'h00, t2c, t2t});
    chk("trickle_pullup_o", 8'h00, {6'h00, trickle});
    acc(1, 3'b100, 8'hff, 8'h00);
    cyc(6);
    chk("weak_keeper_o", 8'h03, {6'h00, keeper});
    chk("timer_inputs", 8'h03, {6'h00, t2c, t2t});
    @(posedge mclk_i);
    low1 <= 2'b01;
    cyc(6);
    chk("weak_keeper_o", 8'h02, {6'h00, keeper});
    chk("trickle_pullup_o", 8'h03, {6'h00, trickle});
    chk("timer_inputs", 8'h01, {6'h00, t2c, t2t});
    acc(1, 3'b001, 8'h00, 8'hfe);
    low1 <= 2'b00;
    $display("test low pins done");
    // latch zero under pwm: pins toggle but timer inputs must stay gated
    acc(1, 3'b100, 8'hfc, 8'h00);
    @(posedge mclk_i);
    pwm_en <= 2'b11;
    // no latch writes while pwm owns the pins
    repeat (4) begin
      @(posedge mclk_i);
      {pwb, pwa} <= 2'($random(seed));
      cyc(4);
      chk("port_one_oe_o", {6'h00, ~pwb, ~pwa}, {6'h00, oe1});
      chk("timer_inputs", 8'h00, {6'h00, t2c, t2t});
    end
    @(posedge mclk_i);
    pwm_en <= 2'b00;
    $display("test pwm done");
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    acc(1, 3'b010, 8'h00, 8'hff);
    cyc(1);
    chk("port_one_oe_o", 8'h00, {6'h00, oe1});
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule : plio_ports_tb
